// File: volt_fold_regs.svh
// Register map, field layout, reset values and scaling constants for the voltage and foldback bank
`ifndef VOLT_FOLD_REGS_SVH
`define VOLT_FOLD_REGS_SVH

// Command codes of the bank
`define CMD_CHAN1_VOLT 8'h32
`define CMD_CHAN2_VOLT 8'h36
`define CMD_CHAN3_VOLT 8'h3a
`define CMD_CHAN4_VOLT 8'h3e
`define CMD_FOLD_SEL 8'h40

// Field layout
`define VCODE_W 14
`define FOLD_DBL_LSB 4
`define FOLD_HOLD_LSB 0
`define CHAN_N 4

// Reset values
`define VOLT_RST 16'h0000
`define FOLD_RST 8'h00
`define UNMAPPED_RD 8'h00

// Class threshold for automatic double limit
`define DBL_CLASS_MIN 4'h4

// Scaling figures, used by software conversion
`define VSTEP_NANOVOLT 3662000
`define VFULL_SCALE_V 60
`define CLASS_ISTEP_NANOAMP 8950
`define LIMIT_FAULT_TIME_MS 60

`endif

// File: volt_fold_pkg.sv
// Types for the voltage and foldback register bank
package volt_fold_pkg;
  typedef enum logic [1:0] {
    SER_IDLE,
    SER_ADDR,
    SER_WRITE,
    SER_READ
  } ser_state_t;
endpackage

// File: volt_fold_bank.sv
// Channel voltage telemetry and foldback/policing selection registers behind a two-wire serial slave
`timescale 1ns/1ps
`include "volt_fold_regs.svh"

module volt_fold_bank
  import volt_fold_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h20 // Arbitrary bus address
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Serial management pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Measurement results, same clock
  input wire logic [`CHAN_N-1:0] conv_valid_i,
  input wire logic [`CHAN_N*`VCODE_W-1:0] conv_code_i,
  // Channel power events and configuration, same clock
  input wire logic [`CHAN_N-1:0] turn_on_i,
  input wire logic [`CHAN_N-1:0] turn_off_i,
  input wire logic [`CHAN_N-1:0] wdog_off_i,
  input wire logic [`CHAN_N-1:0] inrush_i,
  input wire logic [`CHAN_N-1:0] over_limit_i,
  input wire logic [`CHAN_N*4-1:0] assigned_class_i,
  input wire logic [1:0] four_pair_i,
  input wire logic [1:0] single_sig_i,
  // Channel control outputs
  output logic [`CHAN_N-1:0] double_limit_enable_o,
  output logic [`CHAN_N-1:0] limit_2x_active_o,
  output logic [`CHAN_N-1:0] long_fault_time_sel_o,
  output logic [`CHAN_N-1:0] fault_timer_run_o,
  output logic [`CHAN_N-1:0] power_cut_auto_o,
  output logic [`CHAN_N-1:0] power_cut_default_o
);

  // Reset release and pin synchronisers
  logic rst_m_ff;
  logic rst_n_ff;
  logic scl_m_ff;
  logic scl_s_ff;
  logic scl_d_ff;
  logic sda_m_ff;
  logic sda_s_ff;
  logic sda_d_ff;

  // Serial slave state
  ser_state_t st_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic [7:0] hi_snap_ff;
  logic [7:0] cmd_ff;
  logic first_ff;
  logic byte_idx_ff;
  logic sda_oe_ff;

  // Register contents
  logic [15:0] volt_ff [`CHAN_N];
  logic [`CHAN_N-1:0] dbl_ff;
  logic [`CHAN_N-1:0] hold_ff;
  logic [`CHAN_N-1:0] lim2x_ff;
  logic [`CHAN_N-1:0] ftimer_ff;
  logic [`CHAN_N-1:0] pcut_auto_ff;
  logic [`CHAN_N-1:0] pcut_def_ff;

  // Reset release through two flops
  // Release is synchronised so no flop leaves reset on a half-seen edge
  // Assertion stays asynchronous so the pins are quiet even without a clock
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_m_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_m_ff <= 1'b1;
      rst_n_ff <= rst_m_ff;
    end
  end

  // Two-flop pin synchronisers plus one delay stage for edges
  // Pins are asynchronous to the core clock, so only the second and delay stages feed logic
  // Reset level matches the idle bus so no false edge follows reset
  always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_m_ff <= scl_i;
      scl_s_ff <= scl_m_ff;
      scl_d_ff <= scl_s_ff;
      sda_m_ff <= sda_i;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
    end
  end

  // Bus conditions
  // START and STOP are only taken while the synchronised clock stays high
  // Clock and data share the same delay, so their order is kept
  wire scl_rise = scl_s_ff & ~scl_d_ff;
  wire scl_fall = ~scl_s_ff & scl_d_ff;
  wire start_cond = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
  wire stop_cond = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;
  wire byte_done = (bit_cnt_ff == 4'h8);
  wire addr_hit = (shift_ff[7:1] == SLAVE_ADDR);

  // Reset image of the foldback register, split into its two fields
  localparam logic [7:0] FOLD_RST_V = `FOLD_RST;

  // Command codes of the voltage registers, one per channel
  localparam logic [7:0] VOLT_CMD [`CHAN_N] = '{`CMD_CHAN1_VOLT, `CMD_CHAN2_VOLT, `CMD_CHAN3_VOLT, `CMD_CHAN4_VOLT};

  // Command decode and one-hot voltage selection
  // An unmatched command selects nothing, so the mux never leaks a reading
  wire [`CHAN_N-1:0] volt_hit;
  wire [15:0] volt_term [`CHAN_N];
  genvar v;
  generate
    for (v = 0; v < `CHAN_N; v = v + 1) begin : g_vdec
      assign volt_hit[v] = (cmd_ff == VOLT_CMD[v]);
      assign volt_term[v] = volt_hit[v] ? volt_ff[v] : 16'h0000;
    end
  endgenerate
  wire fold_hit = (cmd_ff == `CMD_FOLD_SEL);

  // Read data selection
  // Only one term can be non-zero, so a plain OR merges them
  wire [7:0] fold_rd = {dbl_ff, hold_ff};
  wire [15:0] volt_sel = volt_term[0] | volt_term[1] | volt_term[2] | volt_term[3];
  wire is_volt = |volt_hit;
  wire [7:0] rd_first = is_volt ? volt_sel[7:0] : (fold_hit ? fold_rd : `UNMAPPED_RD);
  wire [7:0] rd_next = (is_volt && !byte_idx_ff) ? hi_snap_ff :
                       (fold_hit ? fold_rd : `UNMAPPED_RD);
  wire host_fold_wr = scl_fall & byte_done & (st_ff == SER_WRITE) & ~first_ff & fold_hit;

  // Serial slave sequencing
  // STOP beats START beats bit traffic; a START aborts any byte in flight
  // Data moves on the synchronised clock fall and is sampled on its rise
  // Both bytes of a voltage read are captured at address time to keep a pair consistent
  always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      st_ff <= SER_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      hi_snap_ff <= 8'h00;
      cmd_ff <= 8'h00;
      first_ff <= 1'b0;
      byte_idx_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (stop_cond) begin
      st_ff <= SER_IDLE;
      sda_oe_ff <= 1'b0;
    end else if (start_cond) begin
      st_ff <= SER_ADDR;
      bit_cnt_ff <= 4'h0;
      sda_oe_ff <= 1'b0;
    end else if (scl_rise && st_ff != SER_IDLE) begin
      if (!byte_done) begin
        shift_ff <= {shift_ff[6:0], sda_s_ff};
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end else begin
        bit_cnt_ff <= 4'h0;
        if (st_ff == SER_READ && sda_s_ff) begin
          st_ff <= SER_IDLE; // Master ended the read
        end
      end
    end else if (scl_fall) begin
      if (byte_done) begin
        case (st_ff)
          SER_ADDR: begin
            if (addr_hit) begin
              sda_oe_ff <= 1'b1;
              st_ff <= shift_ff[0] ? SER_READ : SER_WRITE;
              first_ff <= ~shift_ff[0];
              byte_idx_ff <= 1'b0;
              tx_ff <= rd_first;
              hi_snap_ff <= volt_sel[15:8];
            end else begin
              st_ff <= SER_IDLE;
            end
          end
          SER_WRITE: begin
            sda_oe_ff <= 1'b1;
            first_ff <= 1'b0;
            if (first_ff) begin
              cmd_ff <= shift_ff;
            end
          end
          SER_READ: begin
            sda_oe_ff <= 1'b0;
            tx_ff <= rd_next;
            byte_idx_ff <= 1'b1;
          end
          default: begin
            sda_oe_ff <= 1'b0;
          end
        endcase
      end else if (st_ff == SER_READ) begin
        sda_oe_ff <= ~tx_ff[3'h7 - bit_cnt_ff[2:0]];
      end else begin
        sda_oe_ff <= 1'b0;
      end
    end
  end

  // Per-channel registers and control
  // Each channel knows its partner on a four-pair port and that port's index
  // Hardware events win over a host write landing in the same cycle
  genvar c;
  generate
    for (c = 0; c < `CHAN_N; c = c + 1) begin : g_chan
      localparam int P = c ^ 1;
      localparam int PORT = c / 2;
      wire four_p = four_pair_i[PORT];
      wire ss_4p = four_p & single_sig_i[PORT];
      wire ge4_self = (assigned_class_i[c*4 +: 4] >= `DBL_CLASS_MIN);
      wire ge4_pair = (assigned_class_i[P*4 +: 4] >= `DBL_CLASS_MIN);
      wire hold_eff = hold_ff[c] | (four_p & hold_ff[P]);
      wire auto_evt = turn_on_i[c] | (ss_4p & turn_on_i[P]);
      wire auto_val = (turn_on_i[c] & ge4_self) | (ss_4p & turn_on_i[P] & ge4_pair);
      wire auto_go = auto_evt & ~hold_eff;
      wire dbl_clr = turn_off_i[c] | wdog_off_i[c];

      // Voltage reading: code in low bits, cleared by watchdog turn-off
      always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
          volt_ff[c] <= `VOLT_RST;
        end else if (wdog_off_i[c]) begin
          volt_ff[c] <= `VOLT_RST;
        end else if (conv_valid_i[c]) begin
          volt_ff[c] <= {2'b00, conv_code_i[c*`VCODE_W +: `VCODE_W]};
        end
      end

      // Double-limit bit: turn-off or watchdog turn-off, then turn-on setup, then host write
      always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
          dbl_ff[c] <= FOLD_RST_V[`FOLD_DBL_LSB + c];
        end else if (dbl_clr) begin
          dbl_ff[c] <= 1'b0;
        end else if (auto_go) begin
          dbl_ff[c] <= auto_val;
        end else if (host_fold_wr) begin
          dbl_ff[c] <= shift_ff[`FOLD_DBL_LSB + c];
        end
      end

      // Policing hold bit, cleared at port turn-off
      // The watchdog leaves it alone; only a real turn-off or a host write drops it
      always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
          hold_ff[c] <= FOLD_RST_V[`FOLD_HOLD_LSB + c];
        end else if (turn_off_i[c]) begin
          hold_ff[c] <= 1'b0;
        end else if (host_fold_wr) begin
          hold_ff[c] <= shift_ff[`FOLD_HOLD_LSB + c];
        end
      end

      // Registered channel controls
      always_ff @(posedge core_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
          lim2x_ff[c] <= 1'b0;
          ftimer_ff[c] <= 1'b0;
          pcut_auto_ff[c] <= 1'b0;
          pcut_def_ff[c] <= 1'b0;
        end else begin
          lim2x_ff[c] <= dbl_ff[c] & ~inrush_i[c];
          ftimer_ff[c] <= over_limit_i[c];
          pcut_auto_ff[c] <= auto_go;
          pcut_def_ff[c] <= turn_off_i[c];
        end
      end
    end
  endgenerate

  // Outputs, each from a flop except sda_o, which is tied low
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_ff;
  assign double_limit_enable_o = dbl_ff;
  assign long_fault_time_sel_o = dbl_ff;
  assign limit_2x_active_o = lim2x_ff;
  assign fault_timer_run_o = ftimer_ff;
  assign power_cut_auto_o = pcut_auto_ff;
  assign power_cut_default_o = pcut_def_ff;

  // Class current step constant kept for telemetry software
  localparam int CLASS_ISTEP_NA = `CLASS_ISTEP_NANOAMP;

  // Voltage scaling kept beside the code it describes
  // The bank passes raw codes; software multiplies by the step
  localparam int VSTEP_NV = `VSTEP_NANOVOLT;
  localparam int VFULL_V = `VFULL_SCALE_V;

  // Nominal limit fault time used while a double-limit bit is clear
  localparam int LIMIT_FAULT_MS = `LIMIT_FAULT_TIME_MS;

endmodule // volt_fold_bank

// File: volt_fold_bank_asserts.sv
// Port checks for the voltage and foldback bank
`timescale 1ns/1ps
module volt_fold_bank_asserts (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Channel events and configuration
  input wire logic [3:0] turn_on_i, turn_off_i, wdog_off_i, inrush_i, over_limit_i,
  input wire logic [15:0] assigned_class_i,
  input wire logic [1:0] four_pair_i, single_sig_i,
  // Channel control outputs
  input wire logic [3:0] double_limit_enable_o, limit_2x_active_o, long_fault_time_sel_o,
  input wire logic [3:0] fault_timer_run_o, power_cut_auto_o, power_cut_default_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // Limit and timing outputs against their causes
  a_fault_timer: assert property (fault_timer_run_o == $past(over_limit_i))
    else $error("fault timer lag");
  a_time_select: assert property (long_fault_time_sel_o == double_limit_enable_o)
    else $error("time select");
  a_inrush_gate: assert property (limit_2x_active_o == ($past(double_limit_enable_o) & ~$past(inrush_i)))
    else $error("inrush gating");
  // Clearing on turn-off and watchdog
  a_off_clears: assert property (|turn_off_i |=> (double_limit_enable_o & $past(turn_off_i)) == 4'h0)
    else $error("off clear");
  a_wdog_clears: assert property (|wdog_off_i |=> (double_limit_enable_o & $past(wdog_off_i)) == 4'h0)
    else $error("watchdog clear");
  a_off_default: assert property (|turn_off_i |=> power_cut_default_o == $past(turn_off_i))
    else $error("default pulse");
  // Automatic setup from class
  a_auto_class: assert property (power_cut_auto_o[2] && !$past(four_pair_i[1]) && !$past(turn_off_i[2])
    && !$past(wdog_off_i[2]) |-> double_limit_enable_o[2] == ($past(assigned_class_i[11:8]) >= 4'h4))
    else $error("class setup");
  a_pair_both: assert property (power_cut_auto_o[0] && $past(four_pair_i[0]) && $past(single_sig_i[0])
    && $past(turn_off_i[1:0]) == 2'b00 |-> double_limit_enable_o[1] == double_limit_enable_o[0])
    else $error("pair setup");
  c_auto: cover property (power_cut_auto_o[2]);
  c_pair: cover property (power_cut_auto_o[0] && four_pair_i[0]);
  c_wdog: cover property (|wdog_off_i);
endmodule // volt_fold_bank_asserts
bind volt_fold_bank volt_fold_bank_asserts i_volt_fold_bank_asserts (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .turn_on_i(turn_on_i), .turn_off_i(turn_off_i),
  .wdog_off_i(wdog_off_i), .inrush_i(inrush_i), .over_limit_i(over_limit_i),
  .assigned_class_i(assigned_class_i), .four_pair_i(four_pair_i), .single_sig_i(single_sig_i),
  .double_limit_enable_o(double_limit_enable_o), .limit_2x_active_o(limit_2x_active_o),
  .long_fault_time_sel_o(long_fault_time_sel_o), .fault_timer_run_o(fault_timer_run_o),
  .power_cut_auto_o(power_cut_auto_o), .power_cut_default_o(power_cut_default_o));

// File: host_model.sv
// Host processor model on the two-wire management bus
`timescale 1ns/1ps
module host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h20 // Arbitrary bus address
) (
  // Clock and bus pins
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Core clock wait
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One bit slot, data moved only while clock low
  task automatic bt(input logic b, output logic r);
    sda_low_o <= !b;
    cyc(3);
    scl_o <= 1'b1;
    cyc(6);
    r = sda_i;
    scl_o <= 1'b0;
    cyc(3);
  endtask
  // Start or repeated start
  task automatic st;
    sda_low_o <= 1'b0;
    cyc(3);
    scl_o <= 1'b1;
    cyc(6);
    sda_low_o <= 1'b1;
    cyc(6);
    scl_o <= 1'b0;
    cyc(3);
  endtask
  // Stop, line left released to the pull-up
  task automatic sp;
    sda_low_o <= 1'b1;
    cyc(3);
    scl_o <= 1'b1;
    cyc(6);
    sda_low_o <= 1'b0;
    cyc(6);
  endtask
  // Eight data bits then the acknowledge slot
  task automatic bx(input logic [7:0] d, input logic ack, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
    bt(ack, a);
  endtask
  // Two-byte read, low byte first, NACK on the last
  task automatic rd(input logic [7:0] cmd, output logic [15:0] v);
    logic [7:0] q;
    st();
    bx({DEV_ADDR, 1'b0}, 1'b1, q);
    bx(cmd, 1'b1, q);
    st();
    bx({DEV_ADDR, 1'b1}, 1'b1, q);
    bx(8'hff, 1'b0, v[7:0]);
    bx(8'hff, 1'b1, v[15:8]);
    sp();
  endtask
  // Command and one data byte
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    logic [7:0] q;
    st();
    bx({DEV_ADDR, 1'b0}, 1'b1, q);
    bx(cmd, 1'b1, q);
    bx(d, 1'b1, q);
    sp();
  endtask
endmodule // host_model

// File: test_volt_fold_bank.sv
// Self-checking bench for the voltage and foldback bank
`timescale 1ns/1ps
module test_volt_fold_bank;
  logic clk, nrst, scl, sda_low;
  logic [3:0] cv, on, off, wd, inr, ovl;
  logic [55:0] code;
  logic [15:0] cls, got;
  logic [1:0] fp, ss;
  wire sda_oe;
  wire sda = !(sda_low | sda_oe);
  int miscompares, samples_checked;
  volt_fold_bank i_volt_fold_bank (.core_clk_i(clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe_o(sda_oe), .conv_valid_i(cv), .conv_code_i(code), .turn_on_i(on),
    .turn_off_i(off), .wdog_off_i(wd), .inrush_i(inr), .over_limit_i(ovl), .assigned_class_i(cls),
    .four_pair_i(fp), .single_sig_i(ss), .double_limit_enable_o(), .limit_2x_active_o(),
    .long_fault_time_sel_o(), .fault_timer_run_o(), .power_cut_auto_o(), .power_cut_default_o());
  host_model i_host_model (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Verdict and end of run
  task automatic finish_test;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Read a register and compare both bytes
  task automatic chk(input logic [7:0] cmd, input logic [15:0] e);
    i_host_model.rd(cmd, got);
    samples_checked++;
    if (got !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t cmd %h got %h exp %h", $time, cmd, got, e);
    end
  endtask
  // One-cycle channel event pulses
  task automatic ev(input logic [3:0] o, input logic [3:0] f, input logic [3:0] w);
    on <= o;
    off <= f;
    wd <= w;
    inr <= o;
    ovl <= ovl + 4'h5;
    @(posedge clk);
    {on, off, wd, inr} <= '0;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  initial begin
    {nrst, cv, on, off, wd, inr, ovl, fp, ss, cls} = '0;
    code = {14'h1f5e, 14'h2001, 14'h0123, 14'h3abc};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    chk(8'h40, 16'h0000);
    chk(8'h3e, 16'h0000);
    cv <= 4'hf;
    @(posedge clk);
    cv <= 4'h0;
    for (int c = 0; c < 4; c++) chk(8'h32 + 8'(4 * c), {2'b00, code[c * 14 +: 14]});
    // New conversion lands while the low byte is on the bus, after both bytes are captured
    fork
      chk(8'h32, 16'h3abc);
      begin
        repeat (420) @(posedge clk);
        code[13:0] <= 14'h0555;
        cv <= 4'h1;
        @(posedge clk);
        cv <= 4'h0;
      end
    join
    i_host_model.wr(8'h32, 8'hff);
    chk(8'h32, 16'h0555);
    chk(8'h41, 16'h0000);
    i_host_model.wr(8'h40, 8'ha5);
    chk(8'h40, 16'ha5a5);
    i_host_model.wr(8'h40, 8'h00);
    cls <= 16'h3400;
    ev(4'hc, 4'h0, 4'h0);
    chk(8'h40, 16'h4040);
    i_host_model.wr(8'h40, 8'h48);
    cls <= 16'h5400;
    ev(4'h8, 4'h0, 4'h0);
    chk(8'h40, 16'h4848);
    ev(4'h0, 4'h8, 4'h0);
    chk(8'h40, 16'h4040);
    fp <= 2'b01;
    ss <= 2'b01;
    cls <= 16'h5406;
    ev(4'h1, 4'h0, 4'h0);
    chk(8'h40, 16'h7070);
    ss <= 2'b00;
    cls <= 16'h5424;
    ev(4'h0, 4'h3, 4'h0);
    ev(4'h3, 4'h0, 4'h0);
    chk(8'h40, 16'h5050);
    i_host_model.wr(8'h40, 8'h42);
    cls <= 16'h5427;
    ev(4'h1, 4'h0, 4'h0);
    chk(8'h40, 16'h4242);
    ev(4'h0, 4'h0, 4'h4);
    chk(8'h40, 16'h0202);
    chk(8'h3a, 16'h0000);
    finish_test();
  end
endmodule // test_volt_fold_bank
